// ### bench/coa_mem_model.sv
// behavioural data ram and register space on the far side of the core
`timescale 1ns/1ps
module coa_mem_model
    import coa_pkg::*;
(
    input  wire logic         clk,
    input  wire coa_mem_req_t mem_req,
    output logic [7:0]        mem_rdata
);
    // index is {space, bank, addr}; a ram access with bank set lands in a wrong cell
    logic [7:0] mem [0:1023];

    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = ~i[7:0];
        end
        mem_rdata = 8'h00;
    end

    always @(posedge clk) begin
        if (mem_req.valid && mem_req.write) begin
            mem[{mem_req.space, mem_req.bank, mem_req.addr}] <= mem_req.wdata;
        end
        // data valid one cycle only; otherwise it toggles so stale reads show up
        if (mem_req.valid && !mem_req.write) begin
            mem_rdata <= mem[{mem_req.space, mem_req.bank, mem_req.addr}];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// ### bench/testbench.sv
// self-checking bench for the operand-addressing core
`timescale 1ns/1ps
module testbench
    import coa_pkg::*;
;
    typedef struct packed {
        logic [15:0] ins;
        logic [7:0]  acc;
        logic [7:0]  x;
        logic [7:0]  fl;
        logic [7:0]  sp;
        logic [9:0]  midx;
        logic [7:0]  mval;
    } coa_row_t;

    logic            clk;
    logic            reset;
    logic            instr_valid;
    coa_instr_t      instr;
    logic            instr_ready;
    coa_mem_req_t    mem_req;
    logic [7:0]      mem_rdata;
    coa_core_state_t core_state;
    int              n_mismatch;
    int              tests_run;
    coa_row_t        rows [0:18];

    coa_core u_dut (
        .clk         (clk),
        .reset       (reset),
        .instr_valid (instr_valid),
        .instr       (instr),
        .instr_ready (instr_ready),
        .mem_req     (mem_req),
        .mem_rdata   (mem_rdata),
        .core_state  (core_state)
    );

    coa_mem_model u_mem (
        .clk       (clk),
        .mem_req   (mem_req),
        .mem_rdata (mem_rdata)
    );

    always #50 clk = ~clk;

    task automatic note_fail(input string msg);
        n_mismatch++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            note_fail($sformatf("%s got %h expected %h", what, got, exp));
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            note_fail($sformatf("%s got %h expected %h", what, got, exp));
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            note_fail($sformatf("%s got %b expected %b", what, got, exp));
        end
    endtask

    task automatic give_verdict;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_por;
        chk8(core_state.acc, 8'h00, "acc at reset");
        chk8(core_state.x, 8'h00, "x at reset");
        chk8(core_state.sp, 8'h00, "sp at reset");
        chk16(core_state.pc, 16'h0000, "pc at reset");
        chk8(core_state.flags, FLAGS_POR, "flags at reset");
        chk1(instr_ready, 1'b0, "ready in reset");
        chk1(mem_req.valid, 1'b0, "request in reset");
    endtask

    // hold keeps valid up for extra edges while the core is busy
    task automatic do_instr(input logic [15:0] ins, input int hold);
        int n;
        n = 0;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= coa_instr_t'(ins);
        do begin
            @(posedge clk);
            n++;
        end while (instr_ready !== 1'b1 && n < 20);
        repeat (hold) @(posedge clk);
        instr_valid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (instr_ready !== 1'b1 && n < 40);
        #1;
        if (n >= 40) begin
            note_fail("no completion");
        end
    endtask

    initial begin
        #400000;
        note_fail("watchdog expired");
        give_verdict;
    end

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        n_mismatch = 0;
        tests_run = 0;
        // ins layout: mode[15:14] op[13:11] tgt[10:9] space[8] operand[7:0]
        rows = '{
            '{16'h005a, 8'h5a, 8'h00, 8'h02, 8'h00, 10'h000, 8'h00},
            '{16'h080a, 8'h64, 8'h00, 8'h00, 8'h00, 10'h000, 8'h00},
            '{16'h06f0, 8'h64, 8'hf0, 8'h00, 8'h00, 10'h000, 8'h00},
            '{16'h047e, 8'h64, 8'hf0, 8'h00, 8'h7e, 10'h000, 8'h00},
            '{16'h0e20, 8'h64, 8'h10, 8'h04, 8'h7e, 10'h000, 8'h00},
            '{16'h0215, 8'h64, 8'h10, 8'h15, 8'h7e, 10'h000, 8'h00},
            '{16'h1a13, 8'h64, 8'h10, 8'h11, 8'h7e, 10'h000, 8'h00},
            '{16'h4920, 8'hb9, 8'h10, 8'h11, 8'h7e, 10'h000, 8'h00},
            '{16'h4610, 8'hb9, 8'h33, 8'h11, 8'h7e, 10'h000, 8'h00},
            '{16'h88d2, 8'ha9, 8'h33, 8'h15, 8'h7e, 10'h000, 8'h00},
            '{16'h96dd, 8'ha9, 8'h00, 8'h13, 8'h7e, 10'h000, 8'h00},
            '{16'hc810, 8'ha9, 8'h00, 8'h11, 8'h7e, 10'h010, 8'hdc},
            '{16'hc730, 8'ha9, 8'h00, 8'h11, 8'h7e, 10'h330, 8'h00},
            '{16'h0200, 8'ha9, 8'h00, 8'h00, 8'h7e, 10'h000, 8'h00},
            '{16'hc120, 8'ha9, 8'h00, 8'h00, 8'h7e, 10'h220, 8'ha9},
            '{16'h200f, 8'haf, 8'h00, 8'h00, 8'h7e, 10'h000, 8'h00},
            '{16'h28af, 8'h00, 8'h00, 8'h02, 8'h7e, 10'h000, 8'h00},
            '{16'h5010, 8'h24, 8'h00, 8'h04, 8'h7e, 10'h000, 8'h00},
            '{16'h1024, 8'h00, 8'h00, 8'h02, 8'h7e, 10'h000, 8'h00}
        };
        repeat (20) @(posedge clk);
        chk_por;
        u_mem.mem[10'h010] = 8'h33;
        u_mem.mem[10'h005] = 8'hf0;
        u_mem.mem[10'h220] = 8'h44;
        u_mem.mem[10'h320] = 8'h55;
        u_mem.mem[10'h330] = 8'hff;
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk1(instr_ready, 1'b1, "ready after reset");
        foreach (rows[i]) begin
            do_instr(rows[i].ins, 0);
            chk8(core_state.acc, rows[i].acc, "acc");
            chk8(core_state.x, rows[i].x, "x");
            chk8(core_state.flags, rows[i].fl, "flags");
            chk8(core_state.sp, rows[i].sp, "sp");
            chk16(core_state.pc, 16'(2 * (i + 1)), "pc");
            if (rows[i].midx != 10'h000) begin
                chk8(u_mem.mem[rows[i].midx], rows[i].mval, "memory");
            end
        end
        // a request held while busy must run only once
        do_instr(16'h0801, 1);
        chk8(core_state.acc, 8'h01, "acc after held request");
        chk16(core_state.pc, 16'h0028, "pc after held request");
        // reset right after a take discards the pending sp write
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= coa_instr_t'(16'h0455);
        @(posedge clk);
        instr_valid <= 1'b0;
        reset <= 1'b1;
        @(posedge clk);
        #1;
        chk_por;
        @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk1(instr_ready, 1'b1, "ready after second reset");
        give_verdict;
    end
endmodule

// ### rtl/coa_alu.sv
// arithmetic and logic unit of the operand-addressing core
`timescale 1ns/1ps
module coa_alu
    import coa_pkg::*;
(
    input  wire coa_op_t    op,
    input  wire logic [7:0] dest_val,
    input  wire logic [7:0] src_val,
    output logic [7:0]      result,
    output logic            carry,
    output logic            zero
);
    logic [8:0] wide;

    always_comb begin
        wide = {1'b0, src_val};
        case (op)
            COA_OP_MOVE: wide = {1'b0, src_val};
            COA_OP_ADD:  wide = {1'b0, dest_val} + {1'b0, src_val};
            COA_OP_SUB:  wide = {1'b0, dest_val} - {1'b0, src_val};
            COA_OP_AND:  wide = {1'b0, dest_val & src_val};
            COA_OP_OR:   wide = {1'b0, dest_val | src_val};
            COA_OP_XOR:  wide = {1'b0, dest_val ^ src_val};
            default:     wide = {1'b0, src_val};
        endcase
        result = wide[7:0];
        carry  = wide[8];
        zero   = (wide[7:0] == ZERO_BYTE);
    end

endmodule

// ### rtl/coa_core.sv
// operand addressing and core registers of the 8-bit cpu
`timescale 1ns/1ps
module coa_core
    import coa_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            reset,
    input  wire logic            instr_valid,
    input  wire coa_instr_t      instr,
    output logic                 instr_ready,
    output coa_mem_req_t         mem_req,
    input  wire logic [7:0]      mem_rdata,
    output coa_core_state_t      core_state
);
    coa_state_t   state_reg,   state_next;
    coa_instr_t   ins_reg,     ins_next;
    coa_mem_req_t req_reg,     req_next;
    logic         ready_reg,   ready_next;
    logic [7:0]   acc_reg,     acc_next;
    logic [7:0]   flags_reg,   flags_next;
    logic [7:0]   x_reg,       x_next;
    logic [7:0]   sp_reg,      sp_next;
    logic [15:0]  pc_reg,      pc_next;

    logic         take;
    logic         needs_read;
    logic [7:0]   in_addr;
    logic [7:0]   src_val;
    logic [7:0]   dest_val;
    logic [7:0]   alu_res;
    logic         alu_carry;
    logic         alu_zero;
    logic         ins_to_x;

    assign take     = instr_valid && ready_reg;
    assign ins_to_x = (ins_reg.tgt == COA_TGT_X);

    // a move into memory needs no read of the old value
    always_comb begin
        needs_read = 1'b0;
        in_addr    = instr.operand;
        case (instr.mode)
            COA_SRC_IMM: needs_read = 1'b0;
            COA_SRC_DIR: needs_read = 1'b1;
            COA_SRC_IDX: begin
                needs_read = 1'b1;
                in_addr    = 8'(instr.operand + x_reg);
            end
            COA_DST_DIR: needs_read = (instr.op != COA_OP_MOVE);
            default:     needs_read = 1'b0;
        endcase
    end

    // operand selection for the alu
    always_comb begin
        src_val  = ins_reg.operand;
        dest_val = acc_reg;
        case (ins_reg.mode)
            COA_SRC_IMM: begin
                src_val = ins_reg.operand;
                case (ins_reg.tgt)
                    COA_TGT_ACC:   dest_val = acc_reg;
                    COA_TGT_FLAGS: dest_val = flags_reg;
                    COA_TGT_SP:    dest_val = sp_reg;
                    COA_TGT_X:     dest_val = x_reg;
                    default:       dest_val = acc_reg;
                endcase
            end
            COA_SRC_DIR, COA_SRC_IDX: begin
                src_val  = mem_rdata;
                dest_val = ins_to_x ? x_reg : acc_reg;
            end
            COA_DST_DIR: begin
                src_val  = ins_to_x ? x_reg : acc_reg;
                dest_val = mem_rdata;
            end
            default: begin
                src_val  = ins_reg.operand;
                dest_val = acc_reg;
            end
        endcase
    end

    coa_alu u_alu (
        .op       (ins_reg.op),
        .dest_val (dest_val),
        .src_val  (src_val),
        .result   (alu_res),
        .carry    (alu_carry),
        .zero     (alu_zero)
    );

    // sequencing and memory requests
    always_comb begin
        state_next = state_reg;
        ins_next   = ins_reg;
        req_next   = req_reg;
        req_next.valid = 1'b0;
        req_next.write = 1'b0;
        pc_next    = pc_reg;
        case (state_reg)
            COA_ST_IDLE: begin
                if (take) begin
                    ins_next = instr;
                    pc_next  = 16'(pc_reg + INSTR_LEN);
                    if (needs_read) begin
                        state_next     = COA_ST_READ;
                        req_next.valid = 1'b1;
                        req_next.space = instr.space;
                        // bank only matters in register space
                        req_next.bank  = (instr.space == COA_SPACE_REG) &&
                                         flags_reg[FLAG_BANK];
                        req_next.addr  = in_addr;
                        req_next.wdata = ZERO_BYTE;
                    end else begin
                        state_next = COA_ST_EXEC;
                    end
                end
            end
            COA_ST_READ: state_next = COA_ST_EXEC;
            COA_ST_EXEC: begin
                if (ins_reg.mode == COA_DST_DIR) begin
                    state_next     = COA_ST_WRITE;
                    req_next.valid = 1'b1;
                    req_next.write = 1'b1;
                    req_next.space = ins_reg.space;
                    req_next.bank  = (ins_reg.space == COA_SPACE_REG) &&
                                     flags_reg[FLAG_BANK];
                    req_next.addr  = ins_reg.operand;
                    req_next.wdata = alu_res;
                end else begin
                    state_next = COA_ST_IDLE;
                end
            end
            COA_ST_WRITE: state_next = COA_ST_IDLE;
            default:      state_next = COA_ST_IDLE;
        endcase
        ready_next = (state_next == COA_ST_IDLE);
    end

    // register results; nothing outside instruction execution reaches them
    always_comb begin
        acc_next   = acc_reg;
        flags_next = flags_reg;
        x_next     = x_reg;
        sp_next    = sp_reg;
        if (state_reg == COA_ST_EXEC) begin
            if (ins_reg.op != COA_OP_MOVE) begin
                flags_next[FLAG_ZERO] = alu_zero;
                if (ins_reg.op == COA_OP_ADD || ins_reg.op == COA_OP_SUB) begin
                    flags_next[FLAG_CARRY] = alu_carry;
                end
            end
            case (ins_reg.mode)
                COA_SRC_IMM: begin
                    case (ins_reg.tgt)
                        COA_TGT_ACC:   acc_next = alu_res;
                        COA_TGT_FLAGS: flags_next = (alu_res & FLAGS_WR_MASK) |
                                                    (flags_reg & ~FLAGS_WR_MASK);
                        COA_TGT_SP:    sp_next = alu_res;
                        COA_TGT_X:     x_next = alu_res;
                        default:       acc_next = alu_res;
                    endcase
                end
                COA_SRC_DIR, COA_SRC_IDX: begin
                    if (ins_to_x) begin
                        x_next = alu_res;
                    end else begin
                        acc_next = alu_res;
                    end
                end
                COA_DST_DIR: acc_next = acc_reg;
                default:     acc_next = acc_reg;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= COA_ST_IDLE;
            ins_reg   <= '0;
            req_reg   <= '0;
            ready_reg <= 1'b0;
            acc_reg   <= ACC_POR;
            flags_reg <= FLAGS_POR;
            x_reg     <= X_POR;
            sp_reg    <= SP_POR;
            pc_reg    <= PC_POR;
        end else begin
            state_reg <= state_next;
            ins_reg   <= ins_next;
            req_reg   <= req_next;
            ready_reg <= ready_next;
            acc_reg   <= acc_next;
            flags_reg <= flags_next;
            x_reg     <= x_next;
            sp_reg    <= sp_next;
            pc_reg    <= pc_next;
        end
    end

    assign instr_ready = ready_reg;
    assign mem_req     = req_reg;
    assign core_state  = '{acc: acc_reg, flags: flags_reg, x: x_reg, sp: sp_reg, pc: pc_reg};

    // checks
    logic [7:0] imm_in;
    logic       take_imm_move_acc;
    assign imm_in            = instr.operand;
    assign take_imm_move_acc = take && instr.mode == COA_SRC_IMM &&
                               instr.op == COA_OP_MOVE && instr.tgt == COA_TGT_ACC;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_take;
        take;
    endsequence

    sequence s_imm_move_acc;
        take_imm_move_acc ##1 (state_reg == COA_ST_EXEC);
    endsequence

    property p_x_only_by_exec;
        !$stable(x_reg) |-> $past(state_reg) == COA_ST_EXEC && $past(ins_reg.tgt) == COA_TGT_X;
    endproperty
    a_x_only_by_exec: assert property (p_x_only_by_exec)
        else $error("index changed outside an instruction into x");

    property p_sp_only_by_imm;
        !$stable(sp_reg) |-> $past(state_reg) == COA_ST_EXEC &&
                             $past(ins_reg.mode) == COA_SRC_IMM;
    endproperty
    a_sp_only_by_imm: assert property (p_sp_only_by_imm)
        else $error("stack pointer changed without immediate write");

    property p_pc_step;
        s_take |=> pc_reg == 16'($past(pc_reg) + INSTR_LEN);
    endproperty
    a_pc_step: assert property (p_pc_step)
        else $error("program counter did not advance by two");

    property p_pc_hold;
        !take |=> $stable(pc_reg);
    endproperty
    a_pc_hold: assert property (p_pc_hold)
        else $error("program counter moved without an instruction");

    property p_imm_move_acc;
        s_imm_move_acc |=> acc_reg == $past(imm_in, 2);
    endproperty
    a_imm_move_acc: assert property (p_imm_move_acc)
        else $error("immediate move did not reach accumulator");

    property p_and_flags;
        state_reg == COA_ST_EXEC && ins_reg.mode == COA_SRC_IMM &&
        ins_reg.op == COA_OP_AND && ins_reg.tgt == COA_TGT_FLAGS
        |=> flags_reg == (($past(flags_reg) & ins_reg.operand & FLAGS_WR_MASK) |
                          ($past(flags_reg) & ~FLAGS_WR_MASK));
    endproperty
    a_and_flags: assert property (p_and_flags)
        else $error("and into flags gave wrong value");

    property p_idx_addr;
        state_reg == COA_ST_READ && ins_reg.mode == COA_SRC_IDX
        |-> req_reg.valid && req_reg.addr == 8'(ins_reg.operand + x_reg);
    endproperty
    a_idx_addr: assert property (p_idx_addr)
        else $error("indexed address not operand plus index");

    property p_dst_keeps_acc;
        state_reg == COA_ST_EXEC && ins_reg.mode == COA_DST_DIR
        |=> $stable(acc_reg) && req_reg.valid && req_reg.write &&
            req_reg.addr == ins_reg.operand ##1 state_reg == COA_ST_IDLE;
    endproperty
    a_dst_keeps_acc: assert property (p_dst_keeps_acc)
        else $error("destination write wrong or accumulator changed");

    property p_bank;
        req_reg.valid |-> req_reg.bank == (req_reg.space == COA_SPACE_REG &&
                                           flags_reg[FLAG_BANK]);
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank select does not follow flags bit 4");

    property p_space;
        req_reg.valid |-> req_reg.space == ins_reg.space;
    endproperty
    a_space: assert property (p_space)
        else $error("memory space differs from instruction");

endmodule

// ### rtl/coa_pkg.sv
// shared types and constants for the operand-addressing core
package coa_pkg;

    localparam int         DATA_W      = 8;
    localparam int         PC_W        = 16;
    localparam logic [7:0] ACC_POR     = 8'h00;
    localparam logic [7:0] X_POR       = 8'h00;
    localparam logic [7:0] SP_POR      = 8'h00;
    localparam logic [15:0] PC_POR     = 16'h0000;
    localparam logic [7:0] FLAGS_POR   = 8'h02;
    localparam logic [15:0] INSTR_LEN  = 16'h0002;
    localparam logic [7:0] ZERO_BYTE   = 8'h00;

    localparam int         FLAG_GIE    = 0;
    localparam int         FLAG_ZERO   = 1;
    localparam int         FLAG_CARRY  = 2;
    localparam int         FLAG_SUPER  = 3;
    localparam int         FLAG_BANK   = 4;
    // bits that an instruction may alter in the flags; super and reserved excluded
    localparam logic [7:0] FLAGS_WR_MASK = 8'h17;

    typedef enum logic [1:0] {
        COA_SRC_IMM = 2'h0,
        COA_SRC_DIR = 2'h1,
        COA_SRC_IDX = 2'h2,
        COA_DST_DIR = 2'h3
    } coa_mode_t;

    typedef enum logic [2:0] {
        COA_OP_MOVE = 3'h0,
        COA_OP_ADD  = 3'h1,
        COA_OP_SUB  = 3'h2,
        COA_OP_AND  = 3'h3,
        COA_OP_OR   = 3'h4,
        COA_OP_XOR  = 3'h5
    } coa_op_t;

    typedef enum logic [1:0] {
        COA_TGT_ACC   = 2'h0,
        COA_TGT_FLAGS = 2'h1,
        COA_TGT_SP    = 2'h2,
        COA_TGT_X     = 2'h3
    } coa_tgt_t;

    typedef enum logic {
        COA_SPACE_RAM = 1'b0,
        COA_SPACE_REG = 1'b1
    } coa_space_t;

    typedef enum logic [1:0] {
        COA_ST_IDLE  = 2'b00,
        COA_ST_READ  = 2'b01,
        COA_ST_EXEC  = 2'b11,
        COA_ST_WRITE = 2'b10
    } coa_state_t;

    typedef struct packed {
        coa_mode_t  mode;
        coa_op_t    op;
        coa_tgt_t   tgt;
        coa_space_t space;
        logic [7:0] operand;
    } coa_instr_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        coa_space_t space;
        logic       bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } coa_mem_req_t;

    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  flags;
        logic [7:0]  x;
        logic [7:0]  sp;
        logic [15:0] pc;
    } coa_core_state_t;

endpackage
